// ---- core/ppc_cfg.svh ----
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

`define PPC_NPINS 32
`define PPC_HALF 16
`define PPC_OFF_PCR_LAST 12'h07C
`define PPC_OFF_GPCLR 12'h080
`define PPC_OFF_GPCHR 12'h084
`define PPC_OFF_ISFR 12'h0A0
`define PPC_OFF_CAPS 12'h0A4
`define PPC_BIT_PS 0
`define PPC_BIT_PE 1
`define PPC_BIT_SRE 2
`define PPC_BIT_RSV3 3
`define PPC_BIT_PFE 4
`define PPC_BIT_DSE 6
`define PPC_MUX_LSB 8
`define PPC_MUX_MSB 10
`define PPC_IRQ_SENSE_SELECT_LSB 16
`define PPC_IRQ_SENSE_SELECT_MSB 19
`define PPC_BIT_ISF 24
`define PPC_LOW_MASK 16'h0757
`define PPC_IRQ_SENSE_SELECT_DIS 4'h0
`define PPC_IRQ_SENSE_SELECT_LOW 4'h8
`define PPC_IRQ_SENSE_SELECT_RISE 4'h9
`define PPC_IRQ_SENSE_SELECT_FALL 4'hA
`define PPC_IRQ_SENSE_SELECT_BOTH 4'hB
`define PPC_IRQ_SENSE_SELECT_HIGH 4'hC
`define PPC_MUX_ANALOG 3'h0
`define PPC_PULL_CAP 32'hFFFF_FFFF
`define PPC_SLEW_CAP 32'hFFFF_FFFF
`define PPC_FILT_CAP 32'hFFFF_FFFF
`define PPC_IRQ_CAP 32'hFFFF_FFFF
`define PPC_ZERO32 32'h0000_0000

`endif

// ---- core/ppc_pkg.sv ----
package ppc_pkg;
    typedef logic [31:0] ppc_word_t;
    typedef logic [31:0] ppc_pins_t;
    typedef logic [11:0] ppc_addr_t;
    typedef logic [15:0] ppc_half_t;
    typedef enum logic [1:0] {PPC_IDLE, PPC_ACCESS} ppc_bus_t;
endpackage

// ---- core/ppc_pin_cell.sv ----
`timescale 1ns/100ps
`include "ppc_cfg.svh"

// Lower halfword of one pin's control register plus its pad controls
module ppc_pin_cell #(
    parameter bit HAS_PULL = 1'b1,
    parameter bit HAS_SLEW = 1'b1,
    parameter bit HAS_FILT = 1'b1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Load of the lower halfword
    input wire logic i_load,
    input wire logic [15:0] i_value,
    // Stored halfword and pad controls
    output logic [15:0] o_half,
    output logic o_filter_on,
    output logic o_slow_slew,
    output logic o_pull_up_on,
    output logic o_pull_down_on
);
    logic [15:0] half_q;
    logic [15:0] wmask;
    logic digital;

    // Writable bits; reserved bit 3 never in it, fixed features drop out
    always_comb
    begin
        wmask = `PPC_LOW_MASK;
        wmask[`PPC_BIT_PS] = HAS_PULL;
        wmask[`PPC_BIT_PE] = HAS_PULL;
        wmask[`PPC_BIT_SRE] = HAS_SLEW;
        wmask[`PPC_BIT_PFE] = HAS_FILT;
        wmask[`PPC_BIT_RSV3] = 1'b0;
    end

    // Halfword storage
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            half_q <= 16'h0000;
        else if (i_load)
            half_q <= (half_q & ~wmask) | (i_value & wmask);
    end

    assign o_half = half_q;
    assign digital = half_q[`PPC_MUX_MSB:`PPC_MUX_LSB] != `PPC_MUX_ANALOG;

    // Pad controls, registered; valid for every digital mux slot
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_filter_on <= 1'b0;
            o_slow_slew <= 1'b0;
            o_pull_up_on <= 1'b0;
            o_pull_down_on <= 1'b0;
        end
        else
        begin
            o_filter_on <= digital & half_q[`PPC_BIT_PFE];
            o_slow_slew <= digital & half_q[`PPC_BIT_SRE];
            o_pull_up_on <= digital & half_q[`PPC_BIT_PE] & half_q[`PPC_BIT_PS];
            o_pull_down_on <= digital & half_q[`PPC_BIT_PE] & ~half_q[`PPC_BIT_PS];
        end
    end
endmodule

// ---- core/ppc_port.sv ----
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "ppc_cfg.svh"

// Contract
// - Filter bit off at 0; at 1 filter active only for digital input.
// - Filter, slew and pull settings apply in every digital mux selection.
// - Bit 3 of each pin control register reads zero, writes ignored.
// - Bit 2 selects output slew; applies only for digital output.
// - Pins lacking a feature keep slew and pull bits read-only.
// - Bit 1 enables pull resistor, only while pin is digital input.
// - Bit 0 picks pulldown at 0, pullup at 1, when pull enabled.
// - Low global write loads bits 15:0 of selected pins 0 to 15.
// - High global register does the same for pins 16 to 31.
// - Status register at A0h holds one detect flag per pin.
// - Flags of pins without interrupt capability never set.
// - Flag stays set until a one is written; zero leaves it.
// - Active level re-sets the flag right after it is cleared.
// - Flag visible in pin control register; clearable in either place.
// - Sense codes: 0 off, 8 low, 9 rise, A fall, B both, C high.
// - Analog or disabled mux turns off pulls and filter.
// - Global registers read zero and never touch interrupt configuration.
// - One interrupt output, high while any enabled pin flag is set.
module ppc_port (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire ppc_pkg::ppc_addr_t i_paddr,
    input wire ppc_pkg::ppc_word_t i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic o_pslverr,
    output ppc_pkg::ppc_word_t o_prdata,
    // Pins, synchronous to the clock
    input wire ppc_pkg::ppc_pins_t i_pin,
    // Pad controls
    output ppc_pkg::ppc_pins_t o_filter_on,
    output ppc_pkg::ppc_pins_t o_slow_slew,
    output ppc_pkg::ppc_pins_t o_pull_up_on,
    output ppc_pkg::ppc_pins_t o_pull_down_on,
    output logic [95:0] o_mux_sel,
    // Port interrupt request
    output logic o_irq
);
    import ppc_pkg::*;

    ppc_bus_t bus_q;
    ppc_pins_t flag_q;
    ppc_pins_t pin_q;
    ppc_pins_t hit;
    ppc_pins_t pcr_sel;
    ppc_pins_t half_load;
    ppc_pins_t isfr_clr;
    ppc_pins_t pcr_clr;
    ppc_half_t half_val;
    logic [3:0] sense_q [`PPC_NPINS];
    logic [15:0] half [`PPC_NPINS];
    logic wr_acc;
    logic rd_acc;
    logic full_word;
    logic is_pcr;
    logic [4:0] pcr_idx;
    logic mapped;
    ppc_word_t rdata;
    logic [95:0] mux_d;
    ppc_pins_t irq_cap;
    ppc_pins_t pin_digital;
    ppc_pins_t irq_armed;
    ppc_pins_t flag_set;
    ppc_pins_t flag_clr;
    ppc_word_t pcr_word [`PPC_NPINS];
    logic sel_gpclr;
    logic sel_gpchr;
    logic sel_isfr;
    logic sel_caps;
    logic global_ok;

    // Capability mask lookup for one pin
    function automatic logic cap_bit(input logic [31:0] caps, input int idx);
        begin
            cap_bit = caps[idx];
        end
    endfunction

    // Sense decode shared by all pins
    function automatic logic sense_hit(input logic [3:0] code, input logic now, input logic was);
        begin
            unique case (code)
                `PPC_IRQ_SENSE_SELECT_LOW: sense_hit = ~now;
                `PPC_IRQ_SENSE_SELECT_RISE: sense_hit = now & ~was;
                `PPC_IRQ_SENSE_SELECT_FALL: sense_hit = ~now & was;
                `PPC_IRQ_SENSE_SELECT_BOTH: sense_hit = now ^ was;
                `PPC_IRQ_SENSE_SELECT_HIGH: sense_hit = now;
                default: sense_hit = 1'b0;
            endcase
        end
    endfunction

    // Sense field counts as enabled only for a legal nonzero code
    function automatic logic sense_on(input logic [3:0] code);
        begin
            sense_on = (code >= `PPC_IRQ_SENSE_SELECT_LOW) && (code <= `PPC_IRQ_SENSE_SELECT_HIGH);
        end
    endfunction

    // Access qualifiers; zero wait states
    assign wr_acc = i_psel & i_penable & i_pwrite & o_pready;
    assign rd_acc = i_psel & ~i_penable & ~i_pwrite;
    assign full_word = &i_pstrb;
    assign global_ok = wr_acc & full_word;

    // Address decode, one select per register group
    assign is_pcr = i_paddr <= `PPC_OFF_PCR_LAST;
    assign pcr_idx = i_paddr[6:2];
    assign sel_gpclr = i_paddr == `PPC_OFF_GPCLR;
    assign sel_gpchr = i_paddr == `PPC_OFF_GPCHR;
    assign sel_isfr = i_paddr == `PPC_OFF_ISFR;
    assign sel_caps = i_paddr == `PPC_OFF_CAPS;
    assign mapped = is_pcr | sel_gpclr | sel_gpchr | sel_isfr | sel_caps;

    // Bus phase tracker
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bus_q <= PPC_IDLE;
        end
        else
        begin
            unique case (bus_q)
                PPC_IDLE: bus_q <= (i_psel & ~i_penable) ? PPC_ACCESS : PPC_IDLE;
                PPC_ACCESS: bus_q <= PPC_IDLE;
            endcase
        end
    end

    // Ready answers in the access phase; unmapped addresses report an error
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready <= (bus_q == PPC_IDLE) & i_psel & ~i_penable;
            o_pslverr <= (bus_q == PPC_IDLE) & i_psel & ~i_penable & ~mapped;
        end
    end

    // Which pins take a halfword load, and with what value
    always_comb
    begin
        pcr_sel = '0;
        half_load = '0;
        half_val = i_pwdata[15:0];
        if (wr_acc && is_pcr)
        begin
            pcr_sel[pcr_idx] = 1'b1;
            half_load = pcr_sel;
        end
        else if (global_ok && sel_gpclr)
        begin
            half_load = {16'h0000, i_pwdata[31:16]};
        end
        else if (global_ok && sel_gpchr)
        begin
            half_load = {i_pwdata[31:16], 16'h0000};
        end
    end

    // Flag clears from the status register and from each pin's own register
    always_comb
    begin
        isfr_clr = (wr_acc && sel_isfr) ? i_pwdata : '0;
        pcr_clr = '0;
        if (wr_acc && is_pcr)
        begin
            pcr_clr[pcr_idx] = i_pwdata[`PPC_BIT_ISF];
        end
    end

    // Set and clear requests per pin
    assign flag_set = hit & irq_cap;
    assign flag_clr = isfr_clr | pcr_clr;

    // Pin cells and per-pin interrupt logic
    genvar g;
    generate
        for (g = 0; g < `PPC_NPINS; g++)
        begin : g_pin
            // Per-pin capability, mux and sense qualifiers
            assign irq_cap[g] = cap_bit(`PPC_IRQ_CAP, g);
            assign pin_digital[g] = half[g][`PPC_MUX_MSB:`PPC_MUX_LSB] != `PPC_MUX_ANALOG;
            assign irq_armed[g] = sense_on(sense_q[g]);

            ppc_pin_cell #(
                .HAS_PULL(cap_bit(`PPC_PULL_CAP, g)),
                .HAS_SLEW(cap_bit(`PPC_SLEW_CAP, g)),
                .HAS_FILT(cap_bit(`PPC_FILT_CAP, g))
            ) u_cell (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_load(half_load[g]),
                .i_value(half_val),
                .o_half(half[g]),
                .o_filter_on(o_filter_on[g]),
                .o_slow_slew(o_slow_slew[g]),
                .o_pull_up_on(o_pull_up_on[g]),
                .o_pull_down_on(o_pull_down_on[g])
            );

            // Sense field; only a direct pin register write reaches it
            always_ff @(posedge i_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    sense_q[g] <= `PPC_IRQ_SENSE_SELECT_DIS;
                end
                else if (pcr_sel[g] && full_word && irq_cap[g])
                begin
                    sense_q[g] <= i_pwdata[`PPC_IRQ_SENSE_SELECT_MSB:`PPC_IRQ_SENSE_SELECT_LSB];
                end
            end

            // Sense hit only while the pin is digital
            assign hit[g] = pin_digital[g] && sense_hit(sense_q[g], i_pin[g], pin_q[g]);

            // Word seen when reading this pin's register
            always_comb
            begin
                pcr_word[g] = `PPC_ZERO32;
                pcr_word[g][15:0] = half[g];
                pcr_word[g][`PPC_IRQ_SENSE_SELECT_MSB:`PPC_IRQ_SENSE_SELECT_LSB] = sense_q[g];
                pcr_word[g][`PPC_BIT_ISF] = flag_q[g];
            end

            // Flag: detect wins over a same-cycle clear
            always_ff @(posedge i_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    flag_q[g] <= 1'b0;
                end
                else if (flag_set[g])
                begin
                    flag_q[g] <= 1'b1;
                end
                else if (flag_clr[g])
                begin
                    flag_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Previous pin level for edge sensing
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pin_q <= '0;
        end
        else
        begin
            pin_q <= i_pin;
        end
    end

    // Read mux; global registers read zero
    always_comb
    begin
        rdata = `PPC_ZERO32;
        if (is_pcr)
        begin
            rdata = pcr_word[pcr_idx];
        end
        else if (sel_isfr)
        begin
            rdata = flag_q;
        end
        else if (sel_caps)
        begin
            rdata = `PPC_IRQ_CAP;
        end
        else
        begin
            rdata = `PPC_ZERO32;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_prdata <= `PPC_ZERO32;
        end
        else if (rd_acc)
        begin
            o_prdata <= rdata;
        end
    end

    // Mux selections exported per pin
    always_comb
    begin
        mux_d = '0;
        for (int k = 0; k < `PPC_NPINS; k++)
        begin
            mux_d[k*3 +: 3] = half[k][`PPC_MUX_MSB:`PPC_MUX_LSB];
        end
    end

    // Registered mux selections
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_mux_sel <= '0;
        end
        else
        begin
            o_mux_sel <= mux_d;
        end
    end

    // Port interrupt: any flag of an enabled pin
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= |(flag_q & irq_armed);
        end
    end
endmodule

// ---- test/ppc_port_properties.sv ----
`timescale 1ns/100ps
// Watches bus answers, readback zeros and pad controls of the port
module ppc_port_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Bus
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire ppc_pkg::ppc_addr_t i_paddr,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire ppc_pkg::ppc_word_t o_prdata,
    // Pads and interrupt
    input wire ppc_pkg::ppc_pins_t o_filter_on,
    input wire ppc_pkg::ppc_pins_t o_slow_slew,
    input wire ppc_pkg::ppc_pins_t o_pull_up_on,
    input wire ppc_pkg::ppc_pins_t o_pull_down_on,
    input wire logic [95:0] o_mux_sel,
    input wire logic o_irq
);
    import ppc_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Setup cycles and holes in the map
    wire logic st = i_psel && !i_penable;
    wire logic rd = st && !i_pwrite;
    wire logic bad = i_paddr > 12'h0A4 || (i_paddr > 12'h084 && i_paddr < 12'h0A0);
    ready_next_a: assert property (st |=> o_pready) else $error("ready missing");
    ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held");
    err_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    unmapped_err_a: assert property (st && bad |=> o_pslverr) else $error("hole not refused");
    global_zero_a: assert property (rd && i_paddr[11:3] == 9'h010 |=> o_prdata == 32'h0000_0000)
        else $error("global reads nonzero");
    rsv_zero_a: assert property (rd && i_paddr <= 12'h07C |=> (o_prdata & 32'h0000_F8A8) == 32'h0000_0000)
        else $error("reserved bit set");
    pull_excl_a: assert property ((o_pull_up_on & o_pull_down_on) == 32'h0000_0000)
        else $error("both pulls on");
    analog_off_a: assert property (o_mux_sel[17:15] == 3'h0 && $past(o_mux_sel[17:15]) == 3'h0
        |-> {o_filter_on[5], o_slow_slew[5], o_pull_up_on[5], o_pull_down_on[5]} == 4'h0) else $error("analog pad on");
    // Main scenarios
    cover property (st && i_pwrite);
    cover property (o_pslverr);
    cover property ($rose(o_irq));
endmodule

bind ppc_port ppc_port_chk i_ppc_port_chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_filter_on(o_filter_on), .o_slow_slew(o_slow_slew),
    .o_pull_up_on(o_pull_up_on), .o_pull_down_on(o_pull_down_on), .o_mux_sel(o_mux_sel), .o_irq(o_irq));

// ---- test/ppc_pad_model.sv ----
`timescale 1ns/100ps
// Pads outside the port: external drivers, pull resistors, floating wires
module ppc_pad_model (
    // Clock
    input wire logic i_clk,
    // External drive and pad controls
    input wire ppc_pkg::ppc_pins_t i_drv_en,
    input wire ppc_pkg::ppc_pins_t i_drv_val,
    input wire ppc_pkg::ppc_pins_t i_pull_up_on,
    input wire ppc_pkg::ppc_pins_t i_pull_down_on,
    // Levels seen by the port
    output ppc_pkg::ppc_pins_t o_pin
);
    import ppc_pkg::*;
    ppc_pins_t float_q = 32'h5555_5555;
    // A floating pin never keeps a steady level
    always @(posedge i_clk)
        float_q <= ~float_q;
    // Driver wins, else pullup, pulldown or float
    always_ff @(posedge i_clk)
        o_pin <= (i_drv_en & i_drv_val) | (~i_drv_en & (i_pull_up_on | (~i_pull_down_on & float_q)));
endmodule

// ---- test/port_pin_control_lower_tb_top.sv ----
`timescale 1ns/100ps
module port_pin_control_lower_tb_top;
    import ppc_pkg::*;
    logic i_clk = 0;
    logic i_rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [3:0] pstrb = 4'hF;
    logic [95:0] mux;
    ppc_addr_t paddr = 0;
    ppc_word_t pwdata = 0;
    ppc_word_t rdata, prdata;
    ppc_pins_t drv_val = 0;
    ppc_pins_t pin, filt, slew, pup, pdn;
    logic rerr, pready, perr, irq;
    // Sense code, start level, end level, expected flag
    logic [6:0] tab [7] = '{7'h02, 7'h45, 7'h4C, 7'h55, 7'h5B, 7'h63, 7'h6A};
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    ppc_port i_ppc_port (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_pslverr(perr),
        .o_prdata(prdata), .i_pin(pin), .o_filter_on(filt), .o_slow_slew(slew), .o_pull_up_on(pup),
        .o_pull_down_on(pdn), .o_mux_sel(mux), .o_irq(irq));
    ppc_pad_model i_ppc_pad_model (.i_clk(i_clk), .i_drv_en(32'h0000_0008), .i_drv_val(drv_val),
        .i_pull_up_on(pup), .i_pull_down_on(pdn), .o_pin(pin));

    // 50 MHz clock
    always #10 i_clk = ~i_clk;
    // Hang guard
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One bus transfer, held until ready is seen
    task apb(input logic w, input ppc_addr_t a, input ppc_word_t d);
        int n;
        n = 0;
        @(posedge i_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (pready !== 1'b1);
        chk(n, 1);
        rdata = prdata;
        rerr = perr;
        psel <= 0;
        penable <= 0;
    endtask

    task wr(input ppc_addr_t a, input ppc_word_t d);
        apb(1, a, d);
    endtask

    task rd(input ppc_addr_t a, input ppc_word_t e);
        apb(0, a, 32'h0);
        chk(rdata, e);
    endtask

    // Pad controls of one pin, settled two edges after a write
    function logic [31:0] pad(input int k);
        return {28'h0, filt[k], slew[k], pup[k], pdn[k]};
    endfunction

    task settle(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    initial
    begin
        settle(12);
        i_rst <= 0;
        rd(12'h000, 32'h0);
        rd(12'h0A0, 32'h0);
        wr(12'h014, 32'h0000_07FF);
        rd(12'h014, 32'h0000_0757);
        settle(2);
        chk(pad(5), 32'hE);
        wr(12'h014, 32'h0000_0102);
        settle(2);
        chk(pad(5), 32'h1);
        wr(12'h014, 32'h0000_0016);
        settle(2);
        chk(pad(5), 32'h0);
        wr(12'h080, 32'h0021_0113);
        rd(12'h000, 32'h0000_0113);
        pstrb <= 4'h3;
        wr(12'h080, 32'h0002_0017);
        pstrb <= 4'hF;
        rd(12'h004, 32'h0);
        rd(12'h014, 32'h0000_0113);
        chk(pad(0), 32'hA);
        chk({29'h0, mux[2:0]}, 32'h1);
        wr(12'h084, 32'h8000_0102);
        rd(12'h07C, 32'h0000_0102);
        rd(12'h078, 32'h0);
        rd(12'h080, 32'h0);
        rd(12'h084, 32'h0);
        // Rising edge on a driven pin, then clearing
        wr(12'h00C, 32'h0009_0100);
        drv_val[3] <= 1;
        settle(5);
        rd(12'h0A0, 32'h0000_0008);
        chk({31'h0, irq}, 32'h1);
        wr(12'h0A0, 32'h0);
        rd(12'h00C, 32'h0109_0100);
        wr(12'h0A0, 32'h0000_0008);
        rd(12'h0A0, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // High level held by the pullup of a floating pin
        wr(12'h01C, 32'h000C_0103);
        settle(4);
        rd(12'h0A0, 32'h0000_0080);
        wr(12'h01C, 32'h010C_0102);
        rd(12'h0A0, 32'h0000_0080);
        wr(12'h0A0, 32'h0000_0080);
        rd(12'h0A0, 32'h0);
        // Every sense code, with disable and one reserved code
        foreach (tab[i])
        begin
            drv_val[3] <= tab[i][2];
            settle(3);
            wr(12'h00C, {12'h000, tab[i][6:3], 16'h0100});
            drv_val[3] <= tab[i][1];
            settle(4);
            rd(12'h0A0, {28'h0, tab[i][0], 3'h0});
            wr(12'h00C, 32'h0000_0100);
            wr(12'h0A0, 32'h0000_0008);
        end
        // Holes in the map are refused
        rd(12'h0F0, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        tally_and_finish();
    end
endmodule
